/* File: flash_status_pkg.sv */
// Purpose: shared constants for the flash status and read-config link
// Assumes: one clock, core_clk at 40 MHz
// Notes:   status layout, config layout, reset values, command codes
`default_nettype none
package flash_status_pkg;

    // ==========================================================
    // Status word layout
    localparam int READY_POS      = 7;
    localparam int ERASE_PAUSE_POS = 6;
    localparam int ERASE_FAIL_POS = 5;
    localparam int WRITE_FAIL_POS = 4;
    localparam int SUPPLY_BAD_POS = 3;
    localparam int WRITE_PAUSE_POS = 2;
    localparam int LOCK_HIT_POS   = 1;
    localparam int BANK_ACT_POS   = 0;

    // ==========================================================
    // Configuration word layout and reset value
    localparam int          READ_SEL_POS  = 15;
    localparam int          LAT_LSB       = 11;
    localparam int          LAT_MSB       = 13;
    localparam logic [15:0] CONFIG_RESET  = 16'hBFCF;
    localparam logic [15:0] CONFIG_MASK   = 16'hBFCF;

    // ==========================================================
    // Latency codes
    localparam logic [2:0] LAT_CODE_2 = 3'h2;
    localparam logic [2:0] LAT_CODE_3 = 3'h3;
    localparam logic [2:0] LAT_CODE_4 = 3'h4;
    localparam logic [2:0] LAT_CODE_5 = 3'h5;
    localparam logic [2:0] LAT_CYC_2  = 3'h2;
    localparam logic [2:0] LAT_CYC_3  = 3'h3;
    localparam logic [2:0] LAT_CYC_4  = 3'h4;
    localparam logic [2:0] LAT_CYC_5  = 3'h5;
    localparam logic [2:0] LAT_CYC_RSV = 3'h7;

    // ==========================================================
    // Commands
    typedef enum logic [2:0] {
        CMD_NONE, CMD_PROGRAM, CMD_ERASE, CMD_SUSPEND,
        CMD_RESUME, CMD_CLEAR, CMD_SET_CONFIG, CMD_MULTI_WRITE
    } cmd_t;

    localparam logic [1:0] BANK_RESET = 2'h0;
    localparam logic [7:0] STATUS_RESET = 8'h80;

    // Decode latency field into clock count
    function automatic logic [2:0] lat_cycles(input logic [2:0] code);
        case (code)
            LAT_CODE_2: lat_cycles = LAT_CYC_2;
            LAT_CODE_3: lat_cycles = LAT_CYC_3;
            LAT_CODE_4: lat_cycles = LAT_CYC_4;
            LAT_CODE_5: lat_cycles = LAT_CYC_5;
            default:    lat_cycles = LAT_CYC_RSV;
        endcase
    endfunction

endpackage
`default_nettype wire

/* File: flash_status_if.sv */
// Purpose: link between host controller and flash status logic
// Assumes: both ends on core_clk
// Notes:   command strobe with operands; status and config returned
`timescale 1ns/1ps
`default_nettype none
interface flash_status_if;
    import flash_status_pkg::*;
    logic        cmd_valid;
    cmd_t        cmd_code;
    logic [1:0]  cmd_bank;
    logic [15:0] cmd_data;
    logic [1:0]  addr_bank;
    logic        addr_latch;
    logic [7:0]  status_word;
    logic [15:0] config_word;
    logic        sync_read;
    logic        first_data;

    modport device (
        input  cmd_valid, cmd_code, cmd_bank, cmd_data, addr_bank,
               addr_latch,
        output status_word, config_word, sync_read, first_data
    );
    modport host (
        output cmd_valid, cmd_code, cmd_bank, cmd_data, addr_bank,
               addr_latch,
        input  status_word, config_word, sync_read, first_data
    );
endinterface
`default_nettype wire

/* File: flash_status_device.sv */
// Purpose: status register and read configuration of a banked flash
// Assumes: array events come from the core on core_clk; supply and
//          lock inputs are pins and are synchronised here
// Notes:
`timescale 1ns/1ps
`default_nettype none
module flash_status_device
    import flash_status_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    flash_status_if.device  link,
    input  wire logic       supply_ok_pin,
    input  wire logic       block_locked_pin,
    input  wire logic       op_done,
    input  wire logic       verify_fail,
    input  wire logic       word_accepted,
    output logic            op_active,
    output logic [1:0]      op_bank
);

    // ==========================================================
    // Pin synchronisers
    logic supply_s1_r, supply_s2_r, lock_s1_r, lock_s2_r;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            supply_s1_r <= 1'b0;
            supply_s2_r <= 1'b0;
            lock_s1_r   <= 1'b0;
            lock_s2_r   <= 1'b0;
        end else if (clk_en) begin
            supply_s1_r <= supply_ok_pin;
            supply_s2_r <= supply_s1_r;
            lock_s1_r   <= block_locked_pin;
            lock_s2_r   <= lock_s1_r;
        end
    end

    // ==========================================================
    // Operation state
    typedef enum logic [2:0] {
        ST_IDLE, ST_PROG, ST_ERASE, ST_PROG_SUSP, ST_ERASE_SUSP,
        ST_MULTI, ST_MULTI_EXIT
    } op_state_t;

    op_state_t   state_r, state_nxt;
    logic        erase_fail_r, write_fail_r, supply_bad_r, lock_hit_r;
    logic        word_busy_r;
    logic [1:0]  bank_r;
    logic [15:0] config_r;
    logic [2:0]  lat_cnt_r;
    logic        lat_run_r, first_data_r;
    logic [7:0]  status_r;
    logic        op_active_r;

    wire cmd        = link.cmd_valid;
    wire start_req  = cmd && (state_r == ST_IDLE) &&
                      (link.cmd_code == CMD_PROGRAM ||
                       link.cmd_code == CMD_ERASE ||
                       link.cmd_code == CMD_MULTI_WRITE);
    wire start_bad_supply = start_req && !supply_s2_r;
    wire start_locked = start_req && supply_s2_r && lock_s2_r;
    wire start_ok     = start_req && supply_s2_r && !lock_s2_r;
    wire is_erase     = link.cmd_code == CMD_ERASE;
    wire running      = state_r == ST_PROG || state_r == ST_ERASE ||
                        state_r == ST_MULTI;
    wire fail_evt     = running && op_done && verify_fail;
    wire clear_cmd    = cmd && link.cmd_code == CMD_CLEAR;
    // Started bank counts at once, not a cycle late
    wire [1:0] bank_nxt = start_ok ? link.cmd_bank : bank_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_ok) begin
                    if (is_erase)
                        state_nxt = ST_ERASE;
                    else if (link.cmd_code == CMD_MULTI_WRITE)
                        state_nxt = ST_MULTI;
                    else
                        state_nxt = ST_PROG;
                end
            end
            ST_PROG: begin
                if (op_done)
                    state_nxt = ST_IDLE;
                else if (cmd && link.cmd_code == CMD_SUSPEND)
                    state_nxt = ST_PROG_SUSP;
            end
            ST_ERASE: begin
                if (op_done)
                    state_nxt = ST_IDLE;
                else if (cmd && link.cmd_code == CMD_SUSPEND)
                    state_nxt = ST_ERASE_SUSP;
            end
            ST_PROG_SUSP: begin
                if (cmd && link.cmd_code == CMD_RESUME)
                    state_nxt = ST_PROG;
            end
            ST_ERASE_SUSP: begin
                if (cmd && link.cmd_code == CMD_RESUME)
                    state_nxt = ST_ERASE;
            end
            ST_MULTI: begin
                if (op_done)
                    state_nxt = ST_MULTI_EXIT;
            end
            ST_MULTI_EXIT: state_nxt = ST_IDLE;
            default:       state_nxt = ST_IDLE;
        endcase
    end

    // ==========================================================
    // Status composition
    // busy while an operation runs
    wire ready_nxt = !(state_nxt == ST_PROG || state_nxt == ST_ERASE ||
                       state_nxt == ST_MULTI);
    wire multi_nxt = state_nxt == ST_MULTI;
    wire word_busy_nxt = multi_nxt &&
                         ((cmd && link.cmd_code == CMD_MULTI_WRITE &&
                           state_r == ST_MULTI) ||
                          (word_busy_r && !word_accepted));
    // bank bit forced low whenever ready
    wire bank_bit_nxt = ready_nxt ? 1'b0 :
                        multi_nxt ? word_busy_nxt :
                        (link.addr_bank != bank_nxt);
    wire erase_fail_nxt = (fail_evt && state_r == ST_ERASE) ||
                          (erase_fail_r && !clear_cmd);
    wire write_fail_nxt = (fail_evt && state_r != ST_ERASE) ||
                          (write_fail_r && !clear_cmd);
    wire supply_bad_nxt = start_bad_supply || (supply_bad_r && !clear_cmd);
    wire lock_hit_nxt   = start_locked || (lock_hit_r && !clear_cmd);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r      <= ST_IDLE;
            erase_fail_r <= 1'b0;
            write_fail_r <= 1'b0;
            supply_bad_r <= 1'b0;
            lock_hit_r   <= 1'b0;
            word_busy_r  <= 1'b0;
            bank_r       <= BANK_RESET;
            status_r     <= STATUS_RESET;
            op_active_r  <= 1'b0;
        end else if (clk_en) begin
            state_r      <= state_nxt;
            erase_fail_r <= erase_fail_nxt;
            write_fail_r <= write_fail_nxt;
            supply_bad_r <= supply_bad_nxt;
            lock_hit_r   <= lock_hit_nxt;
            word_busy_r  <= word_busy_nxt;
            bank_r       <= bank_nxt;
            op_active_r  <= !ready_nxt;
            status_r <= {ready_nxt, state_nxt == ST_ERASE_SUSP,
                         erase_fail_nxt, write_fail_nxt, supply_bad_nxt,
                         state_nxt == ST_PROG_SUSP, lock_hit_nxt,
                         bank_bit_nxt};
        end
    end

    // ==========================================================
    // Read configuration
    // latency decoded from field
    wire [2:0] lat_cyc = lat_cycles(config_r[LAT_MSB:LAT_LSB]);
    // sync reads only with read select low
    wire sync_mode = !config_r[READ_SEL_POS];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            config_r     <= CONFIG_RESET;
            lat_cnt_r    <= 3'h0;
            lat_run_r    <= 1'b0;
            first_data_r <= 1'b0;
        end else if (clk_en) begin
            if (cmd && link.cmd_code == CMD_SET_CONFIG)
                config_r <= link.cmd_data & CONFIG_MASK;
            // any bank, any block: no bank check here
            first_data_r <= 1'b0;
            if (link.addr_latch && sync_mode) begin
                lat_cnt_r <= lat_cyc - 3'h1;
                lat_run_r <= 1'b1;
                first_data_r <= (lat_cyc == 3'h1);
            end else if (lat_run_r) begin
                lat_cnt_r <= lat_cnt_r - 3'h1;
                if (lat_cnt_r == 3'h1) begin
                    lat_run_r    <= 1'b0;
                    first_data_r <= 1'b1;
                end
            end
        end
    end

    assign link.status_word = status_r;
    assign link.config_word = config_r;
    assign link.sync_read   = config_r[READ_SEL_POS] ? 1'b0 : 1'b1;
    assign link.first_data  = first_data_r;
    assign op_active = op_active_r;
    assign op_bank   = bank_r;

endmodule
`default_nettype wire

/* File: flash_status_host.sv */
// Purpose: host end issuing commands and watching flash status
// Assumes: device on the same core_clk
// Notes:   one request at a time; words fed only when bank bit low
`timescale 1ns/1ps
`default_nettype none
module flash_status_host
    import flash_status_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    flash_status_if.host    link,
    input  wire logic       req_valid,
    input  wire cmd_t       req_code,
    input  wire logic [1:0] req_bank,
    input  wire logic [15:0] req_data,
    input  wire logic [1:0] rd_bank,
    input  wire logic       rd_latch,
    output logic            req_taken,
    output logic [7:0]      status_seen,
    output logic            error_seen
);

    logic        cmd_valid_r, latch_r, taken_r, err_r;
    cmd_t        cmd_code_r;
    logic [1:0]  cmd_bank_r, addr_bank_r;
    logic [15:0] cmd_data_r;
    logic [7:0]  status_r;

    wire [7:0] st = link.status_word;
    wire errs = st[ERASE_FAIL_POS] | st[WRITE_FAIL_POS] |
                st[SUPPLY_BAD_POS] | st[LOCK_HIT_POS];
    // next word only when bank bit low
    wire word_ok = !(req_code == CMD_MULTI_WRITE && !st[READY_POS] &&
                     st[BANK_ACT_POS]);
    // errors must be cleared before others
    wire err_ok = !errs || req_code == CMD_CLEAR;
    wire [2:0] lat_req = req_data[LAT_MSB:LAT_LSB];
    wire cfg_ok = req_code != CMD_SET_CONFIG ||
                  lat_cycles(lat_req) != LAT_CYC_RSV;
    wire accept = req_valid && word_ok && err_ok && cfg_ok && !cmd_valid_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_valid_r <= 1'b0;
            cmd_code_r  <= CMD_NONE;
            cmd_bank_r  <= 2'h0;
            cmd_data_r  <= 16'h0000;
            addr_bank_r <= 2'h0;
            latch_r     <= 1'b0;
            taken_r     <= 1'b0;
            err_r       <= 1'b0;
            status_r    <= STATUS_RESET;
        end else if (clk_en) begin
            cmd_valid_r <= accept;
            taken_r     <= accept;
            if (accept) begin
                cmd_code_r <= req_code;
                cmd_bank_r <= req_bank;
                cmd_data_r <= req_data;
            end
            addr_bank_r <= rd_bank;
            latch_r     <= rd_latch;
            status_r    <= st;
            err_r       <= errs;
        end
    end

    // latency choice left to the user side, but reserved latency codes are refused
    assign link.cmd_valid  = cmd_valid_r;
    assign link.cmd_code   = cmd_code_r;
    assign link.cmd_bank   = cmd_bank_r;
    assign link.cmd_data   = cmd_data_r;
    assign link.addr_bank  = addr_bank_r;
    assign link.addr_latch = latch_r;
    assign req_taken   = taken_r;
    assign status_seen = status_r;
    assign error_seen  = err_r;

endmodule
`default_nettype wire

/* File: status_link_properties.sv */
// Purpose: checks on the status and config link
// Assumes: one clock, async active-low reset
// Notes:   sees only interface signals, no bind
`timescale 1ns/1ps
`default_nettype none
module status_link_checker
    import flash_status_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        cmd_valid,
    input wire cmd_t        cmd_code,
    input wire logic [15:0] cmd_data,
    input wire logic        addr_latch,
    input wire logic [7:0]  status_word,
    input wire logic [15:0] config_word,
    input wire logic        sync_read,
    input wire logic        first_data
);
    // ==========================================================
    // Decodes
    wire set_cfg  = cmd_valid && (cmd_code == CMD_SET_CONFIG);
    wire clr_cmd  = cmd_valid && (cmd_code == CMD_CLEAR);
    wire prog_cmd = cmd_valid && (cmd_code == CMD_PROGRAM);
    wire res_cmd  = cmd_valid && (cmd_code == CMD_RESUME);
    wire lat_go   = addr_latch && sync_read;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // Properties
    property p_ready_bank;
        status_word[7] |-> !status_word[0];
    endproperty
    a_ready_bank: assert property (p_ready_bank)
        else $error("ready with bank bit high");
    property p_sync_sel;
        sync_read != config_word[15];
    endproperty
    a_sync_sel: assert property (p_sync_sel)
        else $error("read mode disagrees with select bit");
    property p_cfg_only_cmd;
        !$stable(config_word) |-> $past(set_cfg);
    endproperty
    a_cfg_only_cmd: assert property (p_cfg_only_cmd)
        else $error("config changed without command");
    property p_cfg_load;
        set_cfg |=> config_word == ($past(cmd_data) & CONFIG_MASK);
    endproperty
    a_cfg_load: assert property (p_cfg_load)
        else $error("config not loaded");
    // Shortest and longest valid codes bound the latency of codes 2 to 5; reserved codes decode to 7
    property p_lat_two;
        lat_go && config_word[13:11] == LAT_CODE_2 |=>
            !first_data ##1 first_data;
    endproperty
    a_lat_two: assert property (p_lat_two)
        else $error("first data not after 2 cycles");
    property p_lat_five;
        lat_go && config_word[13:11] == LAT_CODE_5 |=>
            !first_data [*4] ##1 first_data;
    endproperty
    a_lat_five: assert property (p_lat_five)
        else $error("first data not after 5 cycles");
    // Aborts may leave ready high, so lock and supply errors excuse it
    property p_busy;
        prog_cmd && status_word[7] |=>
            !status_word[7] || status_word[3] || status_word[1];
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready stayed high after start");
    property p_sticky;
        |($past(status_word) & ~status_word & 8'h3A) |-> $past(clr_cmd);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("error bit dropped without clear");
    property p_clear;
        clr_cmd |=> (status_word & 8'h3A) == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("error bits survived clear");
    property p_resume;
        res_cmd |=> !status_word[6] && !status_word[2];
    endproperty
    a_resume: assert property (p_resume)
        else $error("pause bit stayed after resume");
endmodule
`default_nettype wire

/* File: tb_flash_status_and_read_config.sv */
// Purpose: bench for host and device ends of the status link
// Assumes: core_clk 40 MHz, inputs driven at falling edge
// Notes:   random banks, fail flags and config bits; seed 24
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_and_read_config;
    import flash_status_pkg::*;
    // ==========================================================
    // Signals
    logic        core_clk, arst_n, req_valid, rd_latch, req_taken;
    logic        supply_ok_pin, block_locked_pin, op_done;
    logic        verify_fail, word_accepted, f;
    logic        clk_en, op_active, error_seen;
    logic [7:0]  status_seen;
    cmd_t        req_code, c;
    logic [1:0]  req_bank, rd_bank, b, rb, op_bank;
    logic [15:0] req_data, d;
    logic [2:0]  code;
    logic [5:0]  ef;
    int          bad_count = 0, tests_run = 0, i, n;

    flash_status_if lk ();
    flash_status_device i_flash_status_device (
        .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .link(lk),
        .supply_ok_pin(supply_ok_pin), .block_locked_pin(block_locked_pin),
        .op_done(op_done), .verify_fail(verify_fail),
        .word_accepted(word_accepted), .op_active(op_active),
        .op_bank(op_bank));
    flash_status_host i_flash_status_host (
        .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .link(lk),
        .req_valid(req_valid), .req_code(req_code), .req_bank(req_bank),
        .req_data(req_data), .rd_bank(rd_bank), .rd_latch(rd_latch),
        .req_taken(req_taken), .status_seen(status_seen),
        .error_seen(error_seen));
    status_link_checker i_status_link_checker (
        .core_clk(core_clk), .arst_n(arst_n), .cmd_valid(lk.cmd_valid),
        .cmd_code(lk.cmd_code), .cmd_data(lk.cmd_data),
        .addr_latch(lk.addr_latch), .status_word(lk.status_word),
        .config_word(lk.config_word), .sync_read(lk.sync_read),
        .first_data(lk.first_data));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ==========================================================
    // Expectations and compares
    function automatic logic [7:0] st_exp(input logic rdy,
        input logic [6:1] fl, input logic [1:0] ob, input logic [1:0] ab);
        return {rdy, fl, !rdy && (ob != ab)};
    endfunction
    function automatic int lat_exp(input logic [2:0] cd);
        return (cd >= 3'h2 && cd <= 3'h5) ? int'(cd) : 7;
    endfunction
    task automatic chk_st(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: status %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_cfg(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: config %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            bad_count++;
            $display("unexpected at %0t: %0d cycles not %0d", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Drivers
    task automatic reset_dut();
        arst_n = 1'b0;
        repeat (5) @(negedge core_clk);
        arst_n = 1'b1;
        // Pins pass two flops before the device sees them
        repeat (3) @(negedge core_clk);
        chk_st(lk.status_word, st_exp(1'b1, 6'h00, 2'h0, 2'h0));
        chk_cfg(lk.config_word, CONFIG_RESET);
        chk_cfg({15'h0000, lk.sync_read}, 16'h0000);
    endtask
    task automatic req(input cmd_t cc, input logic [1:0] bb,
        input logic [15:0] dd);
        int k = 0;
        req_code = cc;
        req_bank = bb;
        req_data = dd;
        req_valid = 1'b1;
        do begin
            @(negedge core_clk);
            k++;
        end while (req_taken !== 1'b1 && k < 20);
        req_valid = 1'b0;
        if (k >= 20) chk_n(k, 0);
        @(negedge core_clk);
    endtask
    task automatic end_op(input logic fail);
        op_done = 1'b1;
        verify_fail = fail;
        @(negedge core_clk);
        op_done = 1'b0;
        verify_fail = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic finish_test();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog, far above the few hundred cycles needed
    initial begin
        #250000;
        bad_count++;
        $display("unexpected at %0t: watchdog", $time);
        finish_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {req_valid, rd_latch, op_done, verify_fail, word_accepted} = '0;
        clk_en = 1'b1;
        {supply_ok_pin, block_locked_pin, req_bank, rd_bank} = 6'h20;
        req_code = CMD_NONE;
        req_data = 16'h0000;
        void'($urandom(24));
        reset_dut();
        for (i = 0; i < 8; i++) begin
            b = 2'($urandom);
            rb = 2'($urandom);
            f = 1'($urandom);
            c = i[0] ? CMD_ERASE : CMD_PROGRAM;
            ef = !f ? 6'h00 : (i[0] ? 6'h10 : 6'h08);
            rd_bank = rb;
            req(c, b, 16'h0000);
            chk_st(lk.status_word, st_exp(1'b0, 6'h00, b, rb));
            chk_st({7'h00, op_active}, 8'h01);
            chk_st({6'h00, op_bank}, {6'h00, b});
            end_op(f);
            chk_st(lk.status_word, st_exp(1'b1, ef, b, rb));
            repeat (3) @(negedge core_clk);
            chk_st(lk.status_word, st_exp(1'b1, ef, b, rb));
            chk_st(status_seen, st_exp(1'b1, ef, b, rb));
            chk_st({7'h00, error_seen}, {7'h00, f});
            req(CMD_CLEAR, 2'h0, 16'h0000);
            chk_st(lk.status_word, st_exp(1'b1, 6'h00, b, rb));
        end
        for (i = 0; i < 2; i++) begin
            {block_locked_pin, supply_ok_pin} = i[0] ? 2'b00 : 2'b11;
            repeat (3) @(negedge core_clk);
            req(CMD_PROGRAM, 2'h1, 16'h0000);
            ef = i[0] ? 6'h04 : 6'h01;
            chk_st(lk.status_word, st_exp(1'b1, ef, 2'h1, rb));
            {block_locked_pin, supply_ok_pin} = 2'b01;
            repeat (3) @(negedge core_clk);
            req(CMD_CLEAR, 2'h0, 16'h0000);
        end
        rd_bank = 2'h3;
        for (i = 0; i < 2; i++) begin
            req(i[0] ? CMD_ERASE : CMD_PROGRAM, 2'h3, 16'h0000);
            req(CMD_SUSPEND, 2'h3, 16'h0000);
            ef = i[0] ? 6'h20 : 6'h02;
            chk_st(lk.status_word, st_exp(1'b1, ef, 2'h3, 2'h3));
            req(CMD_RESUME, 2'h3, 16'h0000);
            chk_st(lk.status_word, 8'h00);
            end_op(1'b0);
        end
        req(CMD_MULTI_WRITE, 2'h3, 16'h0000);
        req(CMD_MULTI_WRITE, 2'h3, 16'h5A5A);
        chk_st(lk.status_word, 8'h01);
        word_accepted = 1'b1;
        @(negedge core_clk);
        word_accepted = 1'b0;
        @(negedge core_clk);
        chk_st(lk.status_word, 8'h00);
        end_op(1'b0);
        chk_st(lk.status_word, 8'h80);
        // Frozen clock enable: a failing end is ignored
        req(CMD_PROGRAM, 2'h2, 16'h0000);
        clk_en = 1'b0;
        end_op(1'b1);
        chk_st(lk.status_word, 8'h01);
        clk_en = 1'b1;
        end_op(1'b0);
        chk_st(lk.status_word, 8'h80);
        for (i = 0; i < 4; i++) begin
            code = 3'(i + 2);
            d = (16'($urandom) & 16'h47FF) | {2'b00, code, 11'h000};
            req(CMD_SET_CONFIG, 2'h0, d);
            chk_cfg(lk.config_word, d & CONFIG_MASK);
            chk_cfg({15'h0000, lk.sync_read}, 16'h0001);
            rd_latch = 1'b1;
            @(negedge core_clk);
            rd_latch = 1'b0;
            n = 0;
            while (lk.addr_latch !== 1'b1 && n < 8) begin
                @(negedge core_clk);
                n++;
            end
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (lk.first_data !== 1'b1 && n < 9);
            chk_n(n, lat_exp(code));
        end
        // Async select: a latch must raise no first data
        req(CMD_SET_CONFIG, 2'h0, 16'h97CF);
        chk_cfg({15'h0000, lk.sync_read}, 16'h0000);
        rd_latch = 1'b1;
        @(negedge core_clk);
        rd_latch = 1'b0;
        n = 0;
        repeat (8) begin
            @(negedge core_clk);
            if (lk.first_data !== 1'b0) n++;
        end
        chk_n(n, 0);
        reset_dut();
        finish_test();
    end
endmodule
`default_nettype wire
